// >>> design/fidr_host.sv
// The APB register port and the register offsets are this design's own decisions.
`include "fidr_params.svh"
`default_nettype none

// Overview of operation
// - elevated voltage output follows the control bit, held across all reads
// - protection read puts the sector address on bits 21..12; bit 0 is stored
// - entry command sequence is written with the elevated voltage still following the control bit
// - lock read forces bits 21..12 into the designated window
// - one die select asserted, the other deasserted, on every access
// - reads drive chip enable low, output enable low, write enable high
module fidr_host #(
   parameter logic [7:0] ACC_CYC = 8'(`FIDR_ACC_CYC),
   parameter logic [7:0] WP_CYC  = 8'(`FIDR_WP_CYC),
   parameter logic [7:0] GAP_CYC = 8'(`FIDR_GAP_CYC)
) (
   input  wire logic                    CLK_IN,
   input  wire logic                    RSTN_IN,
   input  wire fidr_pkg::fidr_apb_req_t APB_IN,
   output var  fidr_pkg::fidr_apb_rsp_t APB_OUT,
   input  wire logic [15:0]             FLASH_DQ_IN,
   output var  fidr_pkg::fidr_pins_t    FLASH_OUT
);
   import fidr_pkg::*;

   fidr_regs_t r;
   fidr_regs_t next_r;
   logic       mapped;
   logic       wr_en;
   logic       start;

   ////////////////////////////////////////////////////////////////////////////
   // address helpers

   // the identifier address; every don't-care bit is driven low
   function automatic logic [21:0] id_addr(input fidr_op_t op, input logic [9:0] sel);
      logic [21:0] a;
      logic [9:0]  hi;
      // bit 9 stays low as well; the elevated voltage for that pin has its own output
      a  = 22'h000000;
      hi = sel;
      if (op == OP_LOCK) begin
         // lock polling outside the window is undefined, so clamp it
         if (sel < `FIDR_LOCK_WIN_LO) begin
            hi = `FIDR_LOCK_WIN_LO;
         end else if (sel > `FIDR_LOCK_WIN_HI) begin
            hi = `FIDR_LOCK_WIN_HI;
         end
      end
      a[21:12] = hi;
      unique case (op)
         OP_MFR:  a[3:0] = `FIDR_LOW_MFR;
         OP_DEV1: a[3:0] = `FIDR_LOW_DEV1;
         OP_DEV2: a[3:0] = `FIDR_LOW_DEV2;
         OP_DEV3: a[3:0] = `FIDR_LOW_DEV3;
         OP_PROT: a[3:0] = `FIDR_LOW_PROT;
         OP_LOCK: a[3:0] = `FIDR_LOW_LOCK;
         OP_ENTER, OP_EXIT: a[3:0] = 4'h0;
      endcase
      return a;
   endfunction

   // address of each command write; the bank rides the third one
   function automatic logic [21:0] cmd_addr(input fidr_op_t op, input logic [1:0] step,
                                            input logic [9:0] sel);
      logic [21:0] a;
      a = 22'h000000;
      if (op == OP_ENTER) begin
         unique case (step)
            2'h0:    a[11:0] = `FIDR_CMD_ADDR1;
            2'h1:    a[11:0] = `FIDR_CMD_ADDR2;
            default: a = {sel, `FIDR_CMD_ADDR1};
         endcase
      end
      return a;
   endfunction

   function automatic logic [15:0] cmd_data(input fidr_op_t op, input logic [1:0] step);
      logic [15:0] d;
      d = `FIDR_CMD_RESET;
      if (op == OP_ENTER) begin
         unique case (step)
            2'h0:    d = `FIDR_CMD_DATA1;
            2'h1:    d = `FIDR_CMD_DATA2;
            default: d = `FIDR_CMD_DATA3;
         endcase
      end
      return d;
   endfunction

   // secured words that can no longer be written; the factory part sits at the
   // bottom, so a customer lock only ever adds the part just above it
   function automatic logic [7:0] locked_words(input logic fact, input logic cust);
      logic [7:0] n;
      n = 8'h00;
      if (fact) begin
         n = `FIDR_SEC_WORDS;
         if (cust) begin
            n = `FIDR_SEC_WORDS + `FIDR_SEC_WORDS;
         end
      end
      return n;
   endfunction

   // status word; the lock count sits above the flags so older software ignores it
   function automatic logic [31:0] status_word(input fidr_regs_t s);
      logic [31:0] w;
      w = 32'h00000000;
      w[`FIDR_STAT_BUSY] = s.busy;
      w[`FIDR_STAT_DONE] = s.done;
      w[`FIDR_STAT_MODE] = s.mode_on | s.hv;
      w[`FIDR_STAT_PROT] = s.prot;
      w[`FIDR_STAT_FACT] = s.fact;
      w[`FIDR_STAT_CUST] = s.cust;
      w[`FIDR_STAT_LOCKW +: 8] = locked_words(s.fact, s.cust);
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus decode; the slave never waits, so pready is tied high
   // register map, one aligned word each:
   //   0x00 control: bit 0 start (reads 0), bits 3..1 operation, bit 4 voltage, bit 5 die
   //   0x04 select:  bits 9..0 go out on address bits 21..12 as bank or sector
   //   0x08 status:  busy, done (write 1 to clear), mode, protected, factory, customer,
   //                 bits 15..8 count of secured words that are locked
   //   0x0C data:    bits 15..0 hold the last identifier word read
   // read data is captured in the setup cycle, so a read costs no wait state; the
   // catch is that a register changing in that same cycle shows its old value

   assign mapped = (APB_IN.paddr == `FIDR_CTRL_OFS) || (APB_IN.paddr == `FIDR_SEL_OFS) ||
                   (APB_IN.paddr == `FIDR_STAT_OFS) || (APB_IN.paddr == `FIDR_DATA_OFS);
   assign wr_en  = APB_IN.psel && APB_IN.penable && APB_IN.pwrite && mapped;
   // a start while busy is dropped, not queued: software polls done first
   assign start  = wr_en && (APB_IN.paddr == `FIDR_CTRL_OFS) &&
                   APB_IN.pwdata[`FIDR_CTRL_START] && !r.busy;

   assign APB_OUT.prdata  = r.prdata;
   assign APB_OUT.pready  = 1'b1;
   assign APB_OUT.pslverr = APB_IN.psel && APB_IN.penable && !mapped;
   assign FLASH_OUT       = r.pins;

   ////////////////////////////////////////////////////////////////////////////
   // next state: bus side first, so a finishing operation wins over a clear

   always_comb begin
      next_r = r;

      // read data is picked up in the setup cycle and held through access
      if (APB_IN.psel && !APB_IN.penable) begin
         next_r.prdata = 32'h00000000;
         unique case (APB_IN.paddr)
            `FIDR_CTRL_OFS: next_r.prdata[5:1] = {r.die, r.hv, r.op};
            `FIDR_SEL_OFS:  next_r.prdata[9:0] = r.sel;
            `FIDR_STAT_OFS: next_r.prdata = status_word(r);
            `FIDR_DATA_OFS: next_r.prdata[15:0] = r.word;
            default:        next_r.prdata = 32'h00000000;
         endcase
      end

      // writes; configuration is frozen while an operation runs
      if (wr_en && !r.busy) begin
         unique case (APB_IN.paddr)
            `FIDR_CTRL_OFS: begin
               next_r.op  = fidr_op_t'(APB_IN.pwdata[`FIDR_CTRL_OP_LSB +: 3]);
               next_r.hv  = APB_IN.pwdata[`FIDR_CTRL_HV];
               next_r.die = APB_IN.pwdata[`FIDR_CTRL_DIE];
            end
            `FIDR_SEL_OFS: next_r.sel = APB_IN.pwdata[9:0];
            default: ;
         endcase
      end
      if (wr_en && (APB_IN.paddr == `FIDR_STAT_OFS) && APB_IN.pwdata[`FIDR_STAT_DONE]) begin
         next_r.done = 1'b0;
      end

      // dropping the elevated voltage ends identification mode, so a stale mode bit
      // never outlives the voltage that set it
      if (r.hv && !next_r.hv) begin
         next_r.mode_on = 1'b0;
      end

      // sequencer
      // a read holds the strobes for ACC_CYC cycles and samples in the last one;
      // a command write is WP_CYC cycles low, one of hold, then GAP_CYC idle, and
      // the gap keeps back-to-back operations from overlapping on the flash bus
      next_r.cnt = r.cnt + 8'h01;
      unique case (r.st)
         ST_IDLE: begin
            next_r.cnt = 8'h00;
            if (start) begin
               next_r.busy = 1'b1;
               next_r.step = 2'h0;
               // command path needs no elevated voltage at all
               next_r.st = (next_r.op == OP_ENTER || next_r.op == OP_EXIT) ?
                           ST_WR_LOW : ST_READ;
            end
         end
         ST_READ: begin
            if (r.cnt == ACC_CYC - 8'h01) begin
               next_r.word = FLASH_DQ_IN;
               if (r.op == OP_PROT) begin
                  next_r.prot = FLASH_DQ_IN[0];
               end
               if (r.op == OP_LOCK) begin
                  next_r.fact = FLASH_DQ_IN[7];
                  next_r.cust = FLASH_DQ_IN[6];
               end
               next_r.cnt = 8'h00;
               next_r.st  = ST_GAP;
            end
         end
         ST_WR_LOW: begin
            if (r.cnt == WP_CYC - 8'h01) begin
               next_r.cnt = 8'h00;
               next_r.st  = ST_WR_HIGH;
            end
         end
         ST_WR_HIGH: begin
            // one cycle of data hold after write enable rises
            next_r.cnt = 8'h00;
            next_r.st  = ST_GAP;
         end
         ST_GAP: begin
            if (r.cnt == GAP_CYC - 8'h01) begin
               next_r.cnt = 8'h00;
               if (r.op == OP_ENTER && r.step != `FIDR_LAST_STEP) begin
                  next_r.step = r.step + 2'h1;
                  next_r.st   = ST_WR_LOW;
               end else begin
                  next_r.st   = ST_IDLE;
                  next_r.busy = 1'b0;
                  next_r.done = 1'b1;
                  if (r.op == OP_ENTER) begin
                     next_r.mode_on = 1'b1;
                  end
                  if (r.op == OP_EXIT) begin
                     next_r.mode_on = 1'b0;
                  end
               end
            end
         end
         default: begin
            next_r.st   = ST_IDLE;
            next_r.busy = 1'b0;
         end
      endcase

      // pins follow the next state so they register in step with it
      next_r.pins.elevated_id_voltage = next_r.hv;
      next_r.pins.first_die_select_n  = 1'b1;
      next_r.pins.second_die_select_n = 1'b1;
      next_r.pins.oe_n   = 1'b1;
      next_r.pins.we_n   = 1'b1;
      next_r.pins.dq_oe  = 1'b0;
      next_r.pins.dq_out = 16'h0000;
      next_r.pins.addr   = 22'h000000;
      unique case (next_r.st)
         ST_READ: begin
            next_r.pins.addr = id_addr(next_r.op, next_r.sel);
            next_r.pins.first_die_select_n  = next_r.die;
            next_r.pins.second_die_select_n = !next_r.die;
            next_r.pins.oe_n = 1'b0;
         end
         ST_WR_LOW, ST_WR_HIGH: begin
            next_r.pins.addr   = cmd_addr(next_r.op, next_r.step, next_r.sel);
            next_r.pins.dq_out = cmd_data(next_r.op, next_r.step);
            next_r.pins.dq_oe  = 1'b1;
            next_r.pins.first_die_select_n  = next_r.die;
            next_r.pins.second_die_select_n = !next_r.die;
            next_r.pins.we_n = (next_r.st != ST_WR_LOW);
         end
         // idle and gap keep the defaults above: strobes high, selects high and the
         // data lines released, so the flash owns the bus between operations
         ST_IDLE, ST_GAP: ;
         default: ;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   // the reset is asynchronous so the flash bus is released before any clock runs

   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         r        <= '0;
         r.st     <= ST_IDLE;
         r.op     <= OP_MFR;
         r.sel    <= `FIDR_SEL_RST;
         r.word   <= `FIDR_WORD_RST;
         r.pins.first_die_select_n  <= 1'b1;
         r.pins.second_die_select_n <= 1'b1;
         r.pins.oe_n <= 1'b1;
         r.pins.we_n <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

endmodule // fidr_host
`default_nettype wire

// >>> design/fidr_params.svh
`ifndef FIDR_PARAMS_SVH
`define FIDR_PARAMS_SVH

// register byte offsets on the control bus
`define FIDR_CTRL_OFS      8'h00
`define FIDR_SEL_OFS       8'h04
`define FIDR_STAT_OFS      8'h08
`define FIDR_DATA_OFS      8'h0C

// control register fields
`define FIDR_CTRL_START    0
`define FIDR_CTRL_OP_LSB   1
`define FIDR_CTRL_HV       4
`define FIDR_CTRL_DIE      5

// status register fields
`define FIDR_STAT_BUSY     0
`define FIDR_STAT_DONE     1
`define FIDR_STAT_MODE     2
`define FIDR_STAT_PROT     3
`define FIDR_STAT_FACT     4
`define FIDR_STAT_CUST     5
`define FIDR_STAT_LOCKW    8

// reset values
`define FIDR_SEL_RST       10'h000
`define FIDR_WORD_RST      16'h0000

// timing, in ns, and cycle counts derived from the clock period
`define FIDR_CLK_NS        20
`define FIDR_T_ACC_NS      70
`define FIDR_T_WP_NS       35
`define FIDR_T_GAP_NS      30
`define FIDR_ACC_CYC       ((`FIDR_T_ACC_NS + `FIDR_CLK_NS - 1) / `FIDR_CLK_NS)
`define FIDR_WP_CYC        ((`FIDR_T_WP_NS + `FIDR_CLK_NS - 1) / `FIDR_CLK_NS)
`define FIDR_GAP_CYC       ((`FIDR_T_GAP_NS + `FIDR_CLK_NS - 1) / `FIDR_CLK_NS)

// window for address bits 21..12 while polling the lock indicator
`define FIDR_LOCK_WIN_LO   10'h004
`define FIDR_LOCK_WIN_HI   10'h03F

// low address nibble of each identifier word
`define FIDR_LOW_MFR       4'h0
`define FIDR_LOW_DEV1      4'h1
`define FIDR_LOW_DEV2      4'hE
`define FIDR_LOW_DEV3      4'hF
`define FIDR_LOW_PROT      4'h2
`define FIDR_LOW_LOCK      4'h3

// entry command writes and the reset command
`define FIDR_CMD_ADDR1     12'h555
`define FIDR_CMD_ADDR2     12'h2AA
`define FIDR_CMD_DATA1     16'h00AA
`define FIDR_CMD_DATA2     16'h0055
`define FIDR_CMD_DATA3     16'h0090
`define FIDR_CMD_RESET     16'h00F0
`define FIDR_LAST_STEP     2'h2

// secured region: the factory part and the customer part are each this many words
`define FIDR_SEC_WORDS     8'h40

`endif

// >>> design/fidr_pkg.sv
`default_nettype none
package fidr_pkg;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_READ    = 3'b001,
      ST_WR_LOW  = 3'b010,
      ST_WR_HIGH = 3'b011,
      ST_GAP     = 3'b100
   } fidr_state_t;

   typedef enum logic [2:0] {
      OP_MFR   = 3'b000,
      OP_DEV1  = 3'b001,
      OP_DEV2  = 3'b010,
      OP_DEV3  = 3'b011,
      OP_PROT  = 3'b100,
      OP_LOCK  = 3'b101,
      OP_ENTER = 3'b110,
      OP_EXIT  = 3'b111
   } fidr_op_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } fidr_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } fidr_apb_rsp_t;

   typedef struct packed {
      logic [21:0] addr;
      logic        first_die_select_n;
      logic        second_die_select_n;
      logic        oe_n;
      logic        we_n;
      logic [15:0] dq_out;
      logic        dq_oe;
      logic        elevated_id_voltage;
   } fidr_pins_t;

   typedef struct packed {
      fidr_state_t st;
      fidr_op_t    op;
      logic        hv;
      logic        die;
      logic [9:0]  sel;
      logic        busy;
      logic        done;
      logic        mode_on;
      logic        prot;
      logic        fact;
      logic        cust;
      logic [15:0] word;
      logic [7:0]  cnt;
      logic [1:0]  step;
      logic [31:0] prdata;
      fidr_pins_t  pins;
   } fidr_regs_t;

endpackage : fidr_pkg
`default_nettype wire

// >>> test/fidr_host_asserts.sv
`default_nettype none
module fidr_host_asserts (
   input wire logic                    CLK_IN,
   input wire logic                    RSTN_IN,
   input wire fidr_pkg::fidr_apb_req_t APB_IN,
   input wire fidr_pkg::fidr_apb_rsp_t APB_OUT,
   input wire fidr_pkg::fidr_pins_t    FLASH_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   import fidr_pkg::*;
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   ////////////////////////////////////////
   // short aliases keep the properties on one line
   fidr_pins_t f;
   wire        rd = !FLASH_OUT.oe_n;
   assign f = FLASH_OUT;
   ////////////////////////////////////////
   a_read_strobes: assert property (rd |-> f.we_n && !f.dq_oe)
      else $error("read with write strobe or host drive");
   a_one_die: assert property (
      (rd || !f.we_n) |-> f.first_die_select_n != f.second_die_select_n)
      else $error("die selects not exactly one low");
   a_dont_care: assert property (
      rd |-> f.addr[10] == 1'b0 && f.addr[8] == 1'b0 && f.addr[7:4] == 4'h0)
      else $error("ignored address bits not low");
   a_word_sel: assert property (
      rd |-> f.addr[3:0] inside {4'h0, 4'h1, 4'hE, 4'hF, 4'h2, 4'h3})
      else $error("illegal identifier nibble");
   a_lock_window: assert property (
      rd && f.addr[3:0] == 4'h3 |-> f.addr[21:12] inside {[10'h004:10'h03F]})
      else $error("lock read outside bank window");
   a_read_len: assert property ($fell(f.oe_n) |-> (!f.oe_n)[*4] ##1 f.oe_n)
      else $error("read strobe length wrong");
   a_write_pulse: assert property (
      $fell(f.we_n) |-> (!f.we_n && f.dq_oe)[*2] ##1 f.we_n)
      else $error("command write pulse wrong");
   a_read_steady: assert property (
      rd && $past(rd) |-> $stable(f.addr) && $stable(f.elevated_id_voltage))
      else $error("address or voltage moved in a read");
   // no wait states and an error on words past the data register
   a_zero_wait: assert property (APB_IN.psel && APB_IN.penable |-> APB_OUT.pready)
      else $error("bus access stalled");
   a_unmapped_err: assert property (
      APB_IN.psel && APB_IN.penable && APB_IN.paddr > 8'h0C |-> APB_OUT.pslverr)
      else $error("unmapped access not flagged");
endmodule // fidr_host_asserts

bind fidr_host fidr_host_asserts u_chk (
   .CLK_IN   (CLK_IN),
   .RSTN_IN  (RSTN_IN),
   .APB_IN   (APB_IN),
   .APB_OUT  (APB_OUT),
   .FLASH_OUT(FLASH_OUT)
);
`default_nettype wire

// >>> test/fidr_flash_model.sv
`include "fidr_params.svh"
`default_nettype none
module fidr_flash_model #(
   parameter logic [15:0] MFR_CODE = 16'h00A5, // arbitrary value
   parameter logic [15:0] DEV1     = 16'h1357, // arbitrary value
   parameter logic [15:0] DEV2     = 16'h2468, // arbitrary value
   parameter logic [15:0] DEV3     = 16'h0ACE, // arbitrary value
   parameter logic [15:0] ARR_WORD = 16'h5AA5
) (
   input  wire fidr_pkg::fidr_pins_t PINS_IN,
   input  wire logic [1:0]           LOCK_IN,
   output var  logic [15:0]          DQ_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   import fidr_pkg::*;
   logic [1:0]  step = 2'h0;
   logic        cmd_on = 1'b0;
   logic [2:0]  bank = 3'h0;
   logic        id_on;
   logic        drive;
   logic [15:0] word;
   logic [15:0] last = 16'h0;
   wire         sel_any = !PINS_IN.first_die_select_n || !PINS_IN.second_die_select_n;
   ////////////////////////////////////////
   // commands latch on the rising write strobe, as on the real part
   always @(posedge PINS_IN.we_n) begin
      if (sel_any) begin
         if (PINS_IN.dq_out == `FIDR_CMD_RESET) begin
            cmd_on = 1'b0;
            step = 2'h0;
         end else if (step == 2'h0 && PINS_IN.addr[11:0] == `FIDR_CMD_ADDR1 &&
                      PINS_IN.dq_out == `FIDR_CMD_DATA1) begin
            step = 2'h1;
         end else if (step == 2'h1 && PINS_IN.addr[11:0] == `FIDR_CMD_ADDR2 &&
                      PINS_IN.dq_out == `FIDR_CMD_DATA2) begin
            step = 2'h2;
         end else if (step == 2'h2 && PINS_IN.dq_out == `FIDR_CMD_DATA3) begin
            cmd_on = 1'b1;
            bank = PINS_IN.addr[21:19];
            step = 2'h0;
         end else begin
            step = 2'h0;
         end
      end
   end
   // word decode; under the elevated voltage every bank answers, otherwise only the bank that took the entry
   always @* begin
      id_on = PINS_IN.elevated_id_voltage ||
              (cmd_on && PINS_IN.addr[21:19] == bank);
      drive = sel_any && !PINS_IN.oe_n && PINS_IN.we_n;
      word = ARR_WORD;
      if (id_on && PINS_IN.addr[7:6] == 2'h0) begin
         case (PINS_IN.addr[3:0])
            4'h0:    word = MFR_CODE;
            4'h1:    word = DEV1;
            4'hE:    word = DEV2;
            4'hF:    word = DEV3;
            4'h2:    word = {15'h0, PINS_IN.addr[12]};
            4'h3:    word = {8'h00, LOCK_IN, 6'h00};
            default: word = ARR_WORD;
         endcase
      end
      if (drive) last = word;
   end
   // a released bus shows the inverse of the last word, never a held copy
   assign DQ_OUT = PINS_IN.dq_oe ? PINS_IN.dq_out : (drive ? word : ~last);
endmodule // fidr_flash_model
`default_nettype wire

// >>> test/fidr_host_test.sv
`default_nettype none
module fidr_host_test;
   timeunit 1ns;
   timeprecision 1ns;
   import fidr_pkg::*;
   localparam logic [15:0] MFR = 16'h00A5; // arbitrary value
   localparam logic [15:0] DEV [3] = '{16'h1357, 16'h2468, 16'h0ACE}; // arbitrary values
   localparam logic [15:0] ARR = 16'h5AA5;
   logic          clk;
   logic          rstn;
   fidr_apb_req_t req;
   fidr_apb_rsp_t rsp;
   fidr_pins_t    pins;
   logic [15:0]   dq;
   logic [1:0]    locks;
   logic [31:0]   rd;
   logic [31:0]   stat;
   logic          err;
   logic          hv_on;
   logic          cmd_on;
   logic [2:0]    bank;
   logic [9:0]    cur_sel;
   logic          seen_die;
   int            fails;
   int            num_checks;
   int unsigned   seed;
   ////////////////////////////////////////
   fidr_host uut (.CLK_IN(clk), .RSTN_IN(rstn), .APB_IN(req), .APB_OUT(rsp),
                  .FLASH_DQ_IN(dq), .FLASH_OUT(pins));
   fidr_flash_model #(.MFR_CODE(MFR), .DEV1(DEV[0]), .DEV2(DEV[1]), .DEV3(DEV[2]),
                      .ARR_WORD(ARR)) model (.PINS_IN(pins), .LOCK_IN(locks), .DQ_OUT(dq));
   // the die that the last flash read went to, for the die select check
   always @(posedge clk) begin
      if (!pins.oe_n) seen_die <= pins.first_die_select_n;
   end
   ////////////////////////////////////////
   // clock and a watchdog far beyond the expected run
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      end_sim();
   end
   ////////////////////////////////////////
   task automatic end_sim();
      if (fails == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one bus transfer; an edge passes first so psel is never set twice at one time
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic set_sel(input logic [9:0] s);
      apb(1'b1, 8'h04, {22'h0, s});
      cur_sel = s;
   endtask
   task automatic run_op(input logic [2:0] op, input logic hv, input logic die);
      apb(1'b1, 8'h00, {26'h0, die, hv, op, 1'b1});
      do begin
         apb(1'b0, 8'h08, 32'h0);
         stat = rd;
      end while (stat[1] !== 1'b1);
      apb(1'b1, 8'h08, 32'h2);
   endtask
   // reference word from the selection rules alone
   function automatic logic [15:0] exp_word(input logic [2:0] op, input logic [9:0] s);
      if (!(hv_on || (cmd_on && s[9:7] == bank))) return ARR;
      case (op)
         3'h0:    return MFR;
         3'h1,
         3'h2,
         3'h3:    return DEV[int'(op) - 1];
         3'h4:    return {15'h0, s[0]};
         default: return {8'h00, locks, 6'h00};
      endcase
   endfunction
   task automatic read_id(input logic [2:0] op, input logic die);
      logic [15:0] w;
      logic [7:0]  n;
      run_op(op, hv_on, die);
      w = exp_word(op, cur_sel);
      // locked secured words: 64 for the factory part, 64 more for the customer part
      n = locks[1] ? (locks[0] ? 8'h80 : 8'h40) : 8'h00;
      apb(1'b0, 8'h0C, 32'h0);
      check("data", rd, {16'h0, w});
      check("die", {31'h0, seen_die}, {31'h0, die});
      check("mode", {31'h0, stat[2]}, {31'h0, hv_on | cmd_on});
      if (op == 3'h4) check("prot", {31'h0, stat[3]}, {31'h0, w[0]});
      if (op == 3'h5) check("lock", {30'h0, stat[4], stat[5]}, {30'h0, w[7:6]});
      if (op == 3'h5) check("lockw", {24'h0, stat[15:8]}, {24'h0, n});
   endtask
   ////////////////////////////////////////
   initial begin
      seed = $urandom(63195);
      rstn = 1'b0;
      req = '0;
      locks = 2'h0;
      {hv_on, cmd_on, bank, cur_sel, fails, num_checks} = '0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      // reset contents, then one word past the map
      for (int a = 0; a < 20; a += 4) begin
         apb(1'b0, 8'(a), 32'h0);
         check("reset", rd, 32'h0);
      end
      check("slverr", {31'h0, err}, 32'h1);
      // every word under the elevated voltage, on both dies
      hv_on = 1'b1;
      for (int i = 0; i < 12; i++) begin
         locks <= 2'($urandom);
         // the second lock read asks for a bank above the window, so the clamp is used
         set_sel(i == 5 ? 10'(4 + $urandom % 60) : 10'h040 | 10'($urandom));
         read_id(3'(i % 6), 1'(i / 6));
      end
      // a select write while busy must be dropped
      apb(1'b1, 8'h00, 32'h13);
      apb(1'b1, 8'h04, 32'h3FF);
      apb(1'b0, 8'h04, 32'h0);
      check("sel_kept", rd, {22'h0, cur_sel});
      apb(1'b1, 8'h08, 32'h2);
      hv_on = 1'b0;
      read_id(3'h0, 1'b0);
      // command entry with a bank, then the other bank, then exit
      set_sel(10'($urandom));
      run_op(3'h6, 1'b0, 1'b0);
      cmd_on = 1'b1;
      bank = cur_sel[9:7];
      read_id(3'h0, 1'b0);
      set_sel({~bank, 7'($urandom)});
      read_id(3'h1, 1'b0);
      set_sel({bank, 7'($urandom)});
      read_id(3'h3, 1'b0);
      run_op(3'h7, 1'b0, 1'b0);
      cmd_on = 1'b0;
      read_id(3'h0, 1'b0);
      end_sim();
   end
endmodule // fidr_host_test
`default_nettype wire
